// [hdl/aod_output_regs.sv]
// Output data register bank of a three-axis acceleration sensor.
// The sequencer runs on the converter's link clock; the register bank runs on clk.
// Assumes the converter answers each start with one done pulse on link_clk, and that the
// configuration bits come from registers on clk.
`timescale 1ns/1ps
`default_nettype none

module aod_output_regs #(
  parameter int SAMPLE_PERIOD_CYC = aod_pkg::SAMPLE_PERIOD_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       link_clk,
  output logic            conv_start,
  output logic      [1:0] conv_channel,
  input  wire logic       adc_done,
  input  wire logic [11:0] adc_result,
  input  wire logic       byte_order_select,
  input  wire logic       fast_read,
  input  wire logic       magnitude_enable,
  input  wire logic       rd_stb,
  input  wire logic       wr_stb,
  input  wire logic [7:0] addr,
  output logic      [7:0] rdata,
  output logic      [7:0] next_addr,
  output logic            data_ready_flag
);

  // Sequencer states on the link clock.
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_START = 5'b00010,
    S_WAIT  = 5'b00100,
    S_GAP   = 5'b01000,
    S_PUSH  = 5'b10000
  } aod_seq_e;

  localparam logic [19:0] PERIOD_LAST = 20'(SAMPLE_PERIOD_CYC - 1);
  localparam logic [9:0]  GAP_LAST    = aod_pkg::CONV_GAP_CYC - 10'h001;

  aod_seq_e            state_q;
  aod_seq_e            state_d;
  logic [19:0]         period_cnt_q;
  logic                period_tick;
  logic                pending_q;
  logic [9:0]          gap_cnt_q;
  logic [1:0]          chan_q;
  aod_pkg::aod_sample_s capture_q;

  logic                fifo_wr_ready;
  logic                fifo_rd_valid;
  logic                fifo_rd_ready;
  aod_pkg::aod_sample_s fifo_rd_data;
  logic                load;

  logic [7:0]          temp_q;
  logic [11:0]         x_q;
  logic [11:0]         y_q;
  logic [11:0]         z_q;
  logic [11:0]         mag_q;
  logic [11:0]         mag_d;
  logic                ready_q;
  logic [7:0]          rdata_q;
  logic [7:0]          next_addr_q;
  logic                clears_flag;
  logic                is_low_axis;

  // ---------------- Link clock domain ----------------

  // Output sample period timer; each wrap asks for one full acquisition.
  assign period_tick = (period_cnt_q == PERIOD_LAST);
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_q <= 20'h00000;
    end else if (period_tick) begin
      period_cnt_q <= 20'h00000;
    end else begin
      period_cnt_q <= period_cnt_q + 20'h00001;
    end
  end

  // A request that lands while a sequence still runs is held, not lost; the tick wins over the clear.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= 1'b0;
    end else if (period_tick) begin
      pending_q <= 1'b1;
    end else if (state_q == S_IDLE) begin
      pending_q <= 1'b0;
    end
  end

  // Acquisition order and spacing: temperature, X, Y, Z, one gap between successive starts.
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (pending_q) begin
          state_d = S_START;
        end
      end
      S_START: begin
        state_d = S_WAIT;
      end
      S_WAIT: begin
        if (adc_done) begin
          state_d = (chan_q == aod_pkg::CH_Z_AXIS) ? S_PUSH : S_GAP;
        end
      end
      S_GAP: begin
        if (gap_cnt_q >= GAP_LAST) begin
          state_d = S_START;
        end
      end
      S_PUSH: begin
        // A full buffer stalls the sequencer here until the bank drains it.
        if (fifo_wr_ready) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Gap counter restarts at every start so the spacing is measured start to start.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_q <= 10'h000;
    end else if (state_q == S_START) begin
      gap_cnt_q <= 10'h001;
    end else if ((state_q == S_WAIT || state_q == S_GAP) && gap_cnt_q != 10'h3ff) begin
      gap_cnt_q <= gap_cnt_q + 10'h001;
    end
  end

  // Channel index walks up from temperature and returns to it once the word is queued.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= aod_pkg::CH_TEMPERATURE;
    end else if (state_q == S_IDLE) begin
      chan_q <= aod_pkg::CH_TEMPERATURE;
    end else if (state_q == S_GAP && state_d == S_START) begin
      chan_q <= chan_q + 2'h1;
    end
  end

  // Each result goes into its slot of the word being assembled.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_q <= '0;
    end else if (state_q == S_WAIT && adc_done) begin
      case (chan_q)
        aod_pkg::CH_TEMPERATURE: capture_q.temp <= adc_result[aod_pkg::TEMP_FIELD_MSB:aod_pkg::TEMP_FIELD_LSB];
        aod_pkg::CH_X_AXIS:      capture_q.x    <= adc_result;
        aod_pkg::CH_Y_AXIS:      capture_q.y    <= adc_result;
        aod_pkg::CH_Z_AXIS:      capture_q.z    <= adc_result;
        default:                 capture_q      <= capture_q;
      endcase
    end
  end

  assign conv_start   = (state_q == S_START);
  assign conv_channel = chan_q;

  // Whole samples cross into the register clock as one word, so the four values stay together.
  aod_async_fifo #(
    .WIDTH ($bits(aod_pkg::aod_sample_s)),
    .DEPTH (aod_pkg::SAMPLE_FIFO_DEPTH)
  ) u_fifo (
    .wr_clk   (link_clk),
    .rd_clk   (clk),
    .rst_n    (rst_n),
    .wr_valid (state_q == S_PUSH),
    .wr_ready (fifo_wr_ready),
    .wr_data  (capture_q),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data)
  );

  // ---------------- Register clock domain ----------------

  // A new sample is taken only once the host has consumed the last one, so the buffer absorbs slow hosts.
  assign fifo_rd_ready = !ready_q;
  assign load          = fifo_rd_valid && fifo_rd_ready;

  // Output registers load in one edge from one buffer word.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_q <= aod_pkg::TEMP_RESET_VALUE;
      x_q    <= aod_pkg::SAMPLE_RESET_VALUE;
      y_q    <= aod_pkg::SAMPLE_RESET_VALUE;
      z_q    <= aod_pkg::SAMPLE_RESET_VALUE;
    end else if (load) begin
      temp_q <= fifo_rd_data.temp;
      x_q    <= fifo_rd_data.x;
      y_q    <= fifo_rd_data.y;
      z_q    <= fifo_rd_data.z;
    end
  end

  // Magnitude uses max plus three eighths of the other two; cheap and within about 13 percent of the root.
  function automatic logic [10:0] abs12(input logic [11:0] v);
    logic [11:0] n;
    n = v[aod_pkg::SIGN_BIT] ? (~v + 12'h001) : v;
    return n[11] ? 11'h7ff : n[10:0];
  endfunction : abs12

  always_comb begin
    logic [10:0] ax;
    logic [10:0] ay;
    logic [10:0] az;
    logic [10:0] hi;
    logic [12:0] rest;
    logic [14:0] sum;
    ax   = abs12(fifo_rd_data.x);
    ay   = abs12(fifo_rd_data.y);
    az   = abs12(fifo_rd_data.z);
    hi   = ax;
    rest = {2'h0, ay} + {2'h0, az};
    if (ay >= hi && ay >= az) begin
      hi   = ay;
      rest = {2'h0, ax} + {2'h0, az};
    end else if (az >= hi && az >= ay) begin
      hi   = az;
      rest = {2'h0, ax} + {2'h0, ay};
    end
    sum   = {4'h0, hi} + ((15'(rest) * 15'h0003) >> 3);
    mag_d = (sum > 15'h0fff) ? 12'hfff : sum[11:0];
  end

  // Magnitude keeps its previous value while the calculation is switched off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mag_q <= aod_pkg::SAMPLE_RESET_VALUE;
    end else if (load && magnitude_enable) begin
      mag_q <= mag_d;
    end
  end

  // Reads of the magnitude or axis bytes consume the flag; a load in the same edge wins.
  assign clears_flag = rd_stb && !wr_stb &&
                       (addr >= aod_pkg::MAGNITUDE_LOW_BYTE_OFS) && (addr <= aod_pkg::Z_ACCEL_HIGH_BYTE_OFS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else if (load) begin
      ready_q <= 1'b1;
    end else if (clears_flag) begin
      ready_q <= 1'b0;
    end
  end

  // One axis byte for the given half, order and fast-read setting.
  function automatic logic [7:0] axis_byte(input logic [11:0] s, input logic high, input logic be,
                                           input logic fr);
    logic [7:0] b;
    if (!high && fr) begin
      b = s[11:4];
    end else if (!high) begin
      b = be ? s[11:4] : s[7:0];
    end else if (be) begin
      b = {s[3:0], aod_pkg::NIBBLE_ZERO};
    end else begin
      b = {{4{s[aod_pkg::SIGN_BIT]}}, s[11:8]};
    end
    return b;
  endfunction : axis_byte

  // Read data mux; the temperature byte is the signed offset from the reference point.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= aod_pkg::UNMAPPED_READ_VALUE;
    end else if (rd_stb && !wr_stb) begin
      case (addr)
        aod_pkg::TEMPERATURE_SAMPLE_OFS:  rdata_q <= temp_q;
        aod_pkg::MAGNITUDE_LOW_BYTE_OFS:  rdata_q <= byte_order_select ? mag_q[11:4] : mag_q[7:0];
        aod_pkg::MAGNITUDE_HIGH_BYTE_OFS: rdata_q <= byte_order_select ? {mag_q[3:0], aod_pkg::NIBBLE_ZERO}
                                                                       : {aod_pkg::NIBBLE_ZERO, mag_q[11:8]};
        aod_pkg::X_ACCEL_LOW_BYTE_OFS:    rdata_q <= axis_byte(x_q, 1'b0, byte_order_select, fast_read);
        aod_pkg::X_ACCEL_HIGH_BYTE_OFS:   rdata_q <= axis_byte(x_q, 1'b1, byte_order_select, fast_read);
        aod_pkg::Y_ACCEL_LOW_BYTE_OFS:    rdata_q <= axis_byte(y_q, 1'b0, byte_order_select, fast_read);
        aod_pkg::Y_ACCEL_HIGH_BYTE_OFS:   rdata_q <= axis_byte(y_q, 1'b1, byte_order_select, fast_read);
        aod_pkg::Z_ACCEL_LOW_BYTE_OFS:    rdata_q <= axis_byte(z_q, 1'b0, byte_order_select, fast_read);
        aod_pkg::Z_ACCEL_HIGH_BYTE_OFS:   rdata_q <= axis_byte(z_q, 1'b1, byte_order_select, fast_read);
        default:                          rdata_q <= aod_pkg::UNMAPPED_READ_VALUE;
      endcase
    end
  end

  // Burst address; under fast read the step from an axis low byte jumps over its high byte.
  assign is_low_axis = (addr == aod_pkg::X_ACCEL_LOW_BYTE_OFS) || (addr == aod_pkg::Y_ACCEL_LOW_BYTE_OFS) ||
                       (addr == aod_pkg::Z_ACCEL_LOW_BYTE_OFS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      next_addr_q <= 8'h00;
    end else if (rd_stb && !wr_stb) begin
      next_addr_q <= (fast_read && is_low_axis) ? addr + 8'h02 : addr + 8'h01;
    end
  end

  assign rdata           = rdata_q;
  assign next_addr       = next_addr_q;
  assign data_ready_flag = ready_q;

endmodule : aod_output_regs
`default_nettype wire

// [hdl/aod_pkg.sv]
// Package for the acceleration output data register bank.
// Holds register offsets, field positions, channel codes, timing figures and the sample carrier.
// Assumes the clock rates below match the clocks that the surrounding chip supplies.
package aod_pkg;

  // Register offsets (byte addresses on the serial register port).
  localparam logic [7:0] TEMPERATURE_SAMPLE_OFS  = 8'h01;
  localparam logic [7:0] MAGNITUDE_LOW_BYTE_OFS  = 8'h02;
  localparam logic [7:0] MAGNITUDE_HIGH_BYTE_OFS = 8'h03;
  localparam logic [7:0] X_ACCEL_LOW_BYTE_OFS    = 8'h04;
  localparam logic [7:0] X_ACCEL_HIGH_BYTE_OFS   = 8'h05;
  localparam logic [7:0] Y_ACCEL_LOW_BYTE_OFS    = 8'h06;
  localparam logic [7:0] Y_ACCEL_HIGH_BYTE_OFS   = 8'h07;
  localparam logic [7:0] Z_ACCEL_LOW_BYTE_OFS    = 8'h08;
  localparam logic [7:0] Z_ACCEL_HIGH_BYTE_OFS   = 8'h09;

  // Reset and filler values.
  localparam logic [7:0]  UNMAPPED_READ_VALUE = 8'h00;
  localparam logic [11:0] SAMPLE_RESET_VALUE  = 12'h000;
  localparam logic [7:0]  TEMP_RESET_VALUE    = 8'h00;
  localparam logic [3:0]  NIBBLE_ZERO         = 4'h0;

  // Field positions inside a 12-bit sample.
  localparam int SAMPLE_WIDTH = 12;
  localparam int SIGN_BIT     = 11;
  // The temperature converter result carries its 8-bit value in these bits.
  localparam int TEMP_FIELD_MSB = 11;
  localparam int TEMP_FIELD_LSB = 4;

  // Conversion channel codes, in acquisition order.
  localparam logic [1:0] CH_TEMPERATURE = 2'h0;
  localparam logic [1:0] CH_X_AXIS      = 2'h1;
  localparam logic [1:0] CH_Y_AXIS      = 2'h2;
  localparam logic [1:0] CH_Z_AXIS      = 2'h3;

  // Clock rates and conversion spacing.
  localparam int CLK_HZ        = 20000000;
  localparam int LINK_CLK_HZ   = 12500000;
  localparam int CONV_GAP_NS   = 40000;
  localparam int CONV_GAP_CYC_INT = (CONV_GAP_NS * (LINK_CLK_HZ / 1000)) / 1000000;
  localparam logic [9:0] CONV_GAP_CYC = CONV_GAP_CYC_INT[9:0];
  // Default output sample period of 100 Hz, in link clock cycles.
  localparam int SAMPLE_PERIOD_DEFAULT = LINK_CLK_HZ / 100;

  // Depth of the sample buffer between the two clock domains.
  localparam int SAMPLE_FIFO_DEPTH = 32;

  // One complete output sample, moved as a single word across the domains.
  typedef struct packed {
    logic [7:0]  temp;
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } aod_sample_s;

endpackage : aod_pkg

// [hdl/aod_async_fifo.sv]
// Dual-clock FIFO with gray-coded pointers.
// Assumes both resets are the same asynchronous active-low reset and that DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none
module aod_async_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 32
) (
  input  wire logic             wr_clk,
  input  wire logic             rd_clk,
  input  wire logic             rst_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wbin_q;
  logic [AW:0]      wgray_q;
  logic [AW:0]      rbin_q;
  logic [AW:0]      rgray_q;
  logic [AW:0]      rgray_s1_q;
  logic [AW:0]      rgray_s2_q;
  logic [AW:0]      wgray_s1_q;
  logic [AW:0]      wgray_s2_q;
  logic [AW:0]      wbin_d;
  logic [AW:0]      rbin_d;

  // Full compares against the read pointer seen two flops late, so it is pessimistic, never wrong.
  assign wr_ready = (wgray_q != {~rgray_s2_q[AW:AW-1], rgray_s2_q[AW-2:0]});
  assign rd_valid = (rgray_q != wgray_s2_q);
  assign rd_data  = mem_q[rbin_q[AW-1:0]];
  assign wbin_d   = wbin_q + {{AW{1'b0}}, 1'b1};
  assign rbin_d   = rbin_q + {{AW{1'b0}}, 1'b1};

  // Storage is written only from the write domain.
  always_ff @(posedge wr_clk) begin
    if (wr_valid && wr_ready) begin
      mem_q[wbin_q[AW-1:0]] <= wr_data;
    end
  end

  // Write pointer in binary and gray.
  always_ff @(posedge wr_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else if (wr_valid && wr_ready) begin
      wbin_q  <= wbin_d;
      wgray_q <= wbin_d ^ (wbin_d >> 1);
    end
  end

  // Read pointer in binary and gray.
  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbin_q  <= '0;
      rgray_q <= '0;
    end else if (rd_valid && rd_ready) begin
      rbin_q  <= rbin_d;
      rgray_q <= rbin_d ^ (rbin_d >> 1);
    end
  end

  // Read pointer brought into the write domain.
  always_ff @(posedge wr_clk or negedge rst_n) begin
    if (!rst_n) begin
      rgray_s1_q <= '0;
      rgray_s2_q <= '0;
    end else begin
      rgray_s1_q <= rgray_q;
      rgray_s2_q <= rgray_s1_q;
    end
  end

  // Write pointer brought into the read domain.
  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      wgray_s1_q <= '0;
      wgray_s2_q <= '0;
    end else begin
      wgray_s1_q <= wgray_q;
      wgray_s2_q <= wgray_s1_q;
    end
  end

endmodule : aod_async_fifo
`default_nettype wire

// [tb/aod_adc_model.sv]
// Behavioural converter on the far side of the sequencer: answers each start with one done pulse.
// Assumes conv_start and conv_channel change on link_clk and results come from the bench table.
`timescale 1ns/1ps
`default_nettype none
module aod_adc_model #(
  parameter int DELAY = 3
) (
  input  wire logic              link_clk,
  input  wire logic              rst_n,
  input  wire logic              conv_start,
  input  wire logic [1:0]        conv_channel,
  input  wire logic [3:0][11:0]  vals,
  output logic                   adc_done,
  output logic      [11:0]       adc_result
);
  logic       busy_q;
  logic [5:0] cnt_q;
  logic [1:0] ch_q;

  // Later channels answer more slowly; between answers the result bus toggles so no stale value passes.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q     <= 1'b0;
      cnt_q      <= 6'h00;
      ch_q       <= 2'h0;
      adc_done   <= 1'b0;
      adc_result <= 12'h5a5;
    end else begin
      adc_done   <= 1'b0;
      adc_result <= ~adc_result;
      if (conv_start) begin
        busy_q <= 1'b1;
        ch_q   <= conv_channel;
        cnt_q  <= 6'(DELAY + 8 * int'(conv_channel));
      end else if (busy_q) begin
        if (cnt_q == 6'h00) begin
          adc_done   <= 1'b1;
          adc_result <= vals[ch_q];
          busy_q     <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 6'h01;
        end
      end
    end
  end
endmodule : aod_adc_model
`default_nettype wire

// [tb/aod_output_regs_monitor.sv]
// Checker for the output register bank, bound to its top module.
// Assumes rst_n resets both the clk and the link_clk domains.
`timescale 1ns/1ps
`default_nettype none
module aod_output_regs_monitor #(
  parameter int SAMPLE_PERIOD_CYC = aod_pkg::SAMPLE_PERIOD_DEFAULT
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       link_clk,
  input wire logic       conv_start,
  input wire logic [1:0] conv_channel,
  input wire logic       adc_done,
  input wire logic [11:0] adc_result,
  input wire logic       byte_order_select,
  input wire logic       fast_read,
  input wire logic       magnitude_enable,
  input wire logic       rd_stb,
  input wire logic       wr_stb,
  input wire logic [7:0] addr,
  input wire logic [7:0] rdata,
  input wire logic [7:0] next_addr,
  input wire logic       data_ready_flag
);
  logic       rd_take;
  logic [1:0] last_ch_q;
  logic [9:0] gap_q;

  // A write beside a read wins, so only a lone read counts as taken.
  assign rd_take = rd_stb && !wr_stb;

  // Tracks the previous channel and the link cycles since the previous start.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_ch_q <= 2'h3;
      gap_q     <= 10'h000;
    end else if (conv_start) begin
      last_ch_q <= conv_channel;
      gap_q     <= 10'h001;
    end else if (gap_q != 10'h3ff) begin
      gap_q <= gap_q + 10'h001;
    end
  end

  property p_order;
    @(posedge link_clk) disable iff (!rst_n) conv_start |-> conv_channel == last_ch_q + 2'h1;
  endproperty
  a_order: assert property (p_order) else $error("conversion channel out of order");
  property p_gap;
    @(posedge link_clk) disable iff (!rst_n)
      conv_start && conv_channel != aod_pkg::CH_TEMPERATURE |-> gap_q >= aod_pkg::CONV_GAP_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("conversions spaced too closely");
  property p_pulse;
    @(posedge link_clk) disable iff (!rst_n) conv_start |=> !conv_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("conversion start longer than one cycle");
  property p_flag_clr;
    @(posedge clk) disable iff (!rst_n)
      rd_take && data_ready_flag && addr >= 8'h02 && addr <= 8'h09 |=> !data_ready_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("data ready not cleared by read");
  property p_nxt_fast;
    @(posedge clk) disable iff (!rst_n) rd_take && fast_read && addr == 8'h04 |=> next_addr == 8'h06;
  endproperty
  a_nxt_fast: assert property (p_nxt_fast) else $error("fast burst did not skip high byte");
  property p_nxt;
    @(posedge clk) disable iff (!rst_n) rd_take && !fast_read |=> next_addr == $past(addr) + 8'h01;
  endproperty
  a_nxt: assert property (p_nxt) else $error("burst address not incremented by one");
  property p_le_sx;
    @(posedge clk) disable iff (!rst_n)
      rd_take && !byte_order_select && (addr == 8'h05 || addr == 8'h07 || addr == 8'h09)
      |=> rdata[7:4] == {4{rdata[3]}};
  endproperty
  a_le_sx: assert property (p_le_sx) else $error("high byte not sign extended");
  property p_be_zero;
    @(posedge clk) disable iff (!rst_n)
      rd_take && byte_order_select && (addr == 8'h05 || addr == 8'h07 || addr == 8'h09) |=> rdata[3:0] == 4'h0;
  endproperty
  a_be_zero: assert property (p_be_zero) else $error("big-endian low nibble not zero");
  property p_mag_hi;
    @(posedge clk) disable iff (!rst_n) rd_take && !byte_order_select && addr == 8'h03 |=> rdata[7:4] == 4'h0;
  endproperty
  a_mag_hi: assert property (p_mag_hi) else $error("magnitude high nibble not zero");
  property p_wr_ign;
    @(posedge clk) disable iff (!rst_n) wr_stb |=> $stable(rdata) && $stable(next_addr);
  endproperty
  a_wr_ign: assert property (p_wr_ign) else $error("write changed read port");

  c_flag: cover property (@(posedge clk) disable iff (!rst_n) $rose(data_ready_flag));
  c_fast: cover property (@(posedge clk) disable iff (!rst_n) rd_take && fast_read);
  c_z: cover property (@(posedge link_clk) disable iff (!rst_n) conv_start && conv_channel == 2'h3);
endmodule : aod_output_regs_monitor

bind aod_output_regs aod_output_regs_monitor #(.SAMPLE_PERIOD_CYC(SAMPLE_PERIOD_CYC)) i_aod_output_regs_monitor (
  .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .conv_start(conv_start), .conv_channel(conv_channel),
  .adc_done(adc_done), .adc_result(adc_result), .byte_order_select(byte_order_select), .fast_read(fast_read),
  .magnitude_enable(magnitude_enable), .rd_stb(rd_stb), .wr_stb(wr_stb), .addr(addr), .rdata(rdata),
  .next_addr(next_addr), .data_ready_flag(data_ready_flag));
`default_nettype wire

// [tb/aod_output_regs_tb_top.sv]
// Self-checking bench for the output register bank with a converter model on the link side.
// Assumes the register port answers one clk cycle after a taken read.
`timescale 1ns/1ps
`default_nettype none
module aod_output_regs_tb_top;
  logic clk, link_clk, rst_n, conv_start, adc_done, bos, fast_read, mag_en, rd_stb, wr_stb, flag;
  logic [1:0] conv_channel;
  logic [11:0] adc_result;
  logic [3:0][11:0] vals;
  logic [7:0] addr, rdata, next_addr;
  logic [7:0] be_hi;
  logic [15:0] be_word;
  int num_errors = 0;
  int compares = 0;

  aod_output_regs #(.SAMPLE_PERIOD_CYC(3000)) i_aod_output_regs (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .conv_start(conv_start), .conv_channel(conv_channel),
    .adc_done(adc_done), .adc_result(adc_result), .byte_order_select(bos), .fast_read(fast_read),
    .magnitude_enable(mag_en), .rd_stb(rd_stb), .wr_stb(wr_stb), .addr(addr), .rdata(rdata),
    .next_addr(next_addr), .data_ready_flag(flag));
  aod_adc_model i_aod_adc_model (.link_clk(link_clk), .rst_n(rst_n), .conv_start(conv_start),
    .conv_channel(conv_channel), .vals(vals), .adc_done(adc_done), .adc_result(adc_result));

  // The two clocks are unrelated, so the link clock starts off an odd phase.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Reads are one-cycle strobes launched at the falling edge; the answer is settled a cycle later.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] n);
    @(negedge clk);
    addr = a;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    chk(rdata, e);
    chk(next_addr, n);
  endtask : rd

  // A new sample lands every few thousand cycles; a missing one ends the run.
  task automatic wait_flag();
    int i;
    for (i = 0; i < 12000 && flag !== 1'b1; i++) @(negedge clk);
    if (flag !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      tally_and_finish();
    end
  endtask : wait_flag

  // Values only change right after a load, while the sequencer is idle, so no sample mixes two sets.
  initial begin
    {rst_n, bos, fast_read, rd_stb, wr_stb} = 5'h00;
    mag_en = 1'b1;
    addr = 8'h00;
    vals = {12'hff8, 12'h078, 12'h8f3, 12'h9a0};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h02, 8'h00, 8'h03);
    rd(8'h03, 8'h00, 8'h04);
    chk({7'h00, flag}, 8'h00);
    $display("test reset done");
    wait_flag();
    vals = {12'h008, 12'hf00, 12'h123, 12'h120};
    rd(8'h01, 8'h9a, 8'h02);
    rd(8'h04, 8'hf3, 8'h05);
    chk({7'h00, flag}, 8'h00);
    rd(8'h05, 8'hf8, 8'h06);
    rd(8'h06, 8'h78, 8'h07);
    rd(8'h07, 8'h00, 8'h08);
    rd(8'h08, 8'hf8, 8'h09);
    rd(8'h09, 8'hff, 8'h0a);
    rd(8'h02, 8'h3d, 8'h03);
    rd(8'h03, 8'h07, 8'h04);
    rd(8'h0c, 8'h00, 8'h0d);
    $display("test little endian done");
    bos = 1'b1;
    rd(8'h04, 8'h8f, 8'h05);
    be_hi = rdata;
    rd(8'h05, 8'h30, 8'h06);
    // A big-endian host joins the pair, then shifts right by four keeping the sign.
    be_word = $signed({be_hi, rdata}) >>> 4;
    chk(be_word[15:8], 8'hf8);
    chk(be_word[7:0], 8'hf3);
    rd(8'h09, 8'h80, 8'h0a);
    rd(8'h02, 8'h73, 8'h03);
    rd(8'h03, 8'hd0, 8'h04);
    $display("test big endian done");
    {bos, fast_read} = 2'b01;
    rd(8'h04, 8'h8f, 8'h06);
    rd(8'h06, 8'h07, 8'h08);
    // Fast read must also skip under big-endian order.
    bos = 1'b1;
    rd(8'h08, 8'hff, 8'h0a);
    rd(8'h09, 8'h80, 8'h0a);
    @(negedge clk);
    {addr, rd_stb, wr_stb} = {8'h04, 2'b11};
    @(negedge clk);
    {rd_stb, wr_stb, fast_read, bos} = 4'h0;
    chk(rdata, 8'h80);
    chk(next_addr, 8'h0a);
    $display("test fast read and write done");
    wait_flag();
    vals = {12'h000, 12'h000, 12'h000, 12'h7f0};
    mag_en = 1'b0;
    rd(8'h01, 8'h12, 8'h02);
    chk({7'h00, flag}, 8'h01);
    rd(8'h02, 8'h86, 8'h03);
    chk({7'h00, flag}, 8'h00);
    rd(8'h05, 8'h01, 8'h06);
    $display("test refresh done");
    wait_flag();
    rd(8'h01, 8'h7f, 8'h02);
    rd(8'h02, 8'h86, 8'h03);
    rd(8'h04, 8'h00, 8'h05);
    $display("test magnitude hold done");
    tally_and_finish();
  end
endmodule : aod_output_regs_tb_top
`default_nettype wire
